// ===== verification/drib_far_side.sv
// far side model: byte-wide boot memory and a host writing over internal dma
// assumes the bench sets the word gap and tells the host when to write
`timescale 1ns/1ps
`default_nettype none
module drib_far_side (
   input  wire logic        i_clock,
   input  wire logic        i_boot,
   input  wire logic        i_host_go,
   input  wire logic [2:0]  i_gap,
   output logic             o_word_done,
   output logic             o_write,
   output logic [15:0]      o_addr
);
   logic [2:0] cnt = 3'h0;
   // boot memory hands over one word every gap+1 cycles while asked
   always_ff @(posedge i_clock) begin
      cnt <= (cnt == 3'h0) ? i_gap : cnt - 3'h1;
      o_word_done <= i_boot && cnt == 3'h0;
   end
   // host writes location one first, then location zero; address wanders when idle
   always_ff @(posedge i_clock) begin
      o_write <= i_host_go;
      o_addr <= i_host_go ? (o_write ? 16'h0000 : 16'h0001) : ~o_addr;
   end
endmodule
`default_nettype wire

// ===== verification/drib_sysctl_tb.sv
// bench for the reset, idle and boot control block with a far side model
// assumes the recovery count parameter is shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module drib_sysctl_tb;
   import drib_pkg::*;
   logic i_clock, i_reset, i_reset_pin_n, i_powerdown_request_pin_n, i_bus_request_pin;
   logic i_powerdown_force, i_oscillator_disabled, i_irq_pending, i_idle_request;
   logic i_clock_output_disable_bit, i_byte_dma_word_done, i_internal_dma_write;
   logic i_internal_dma_to_pm, i_host_ack_active, host_go, cko_q, d;
   logic [15:0] i_internal_dma_addr, o_fetch_addr;
   logic [2:0]  i_dma_steal_request, gap, o_dma_grant;
   drib_strap_t i_strap_pins;
   drib_div_t   i_idle_divisor;
   logic o_powerdown_ack_pin, o_master_clear, o_run, o_resume, o_fetch_external;
   logic o_byte_dma_boot, o_core_clk_en, o_periph_clk_en, o_cycle_clock_output;
   logic o_flag_pin_two_free, o_host_dma_acknowledge_out, o_host_dma_acknowledge_oe;
   logic [13:0] o_ext_addr_oe;
   drib_cfg_t   o_config;
   int errors = 0, tests_run = 0, words, n, ce, pe, tg, sh, rec;
   int codes[6] = '{0, 4, 5, 6, 7, 2};

   drib_sysctl #(.SLOW_REC_CYCLES(20)) uut (.*);
   drib_far_side far (.i_clock(i_clock), .i_boot(o_byte_dma_boot), .i_host_go(host_go),
      .i_gap(gap), .o_word_done(i_byte_dma_word_done), .o_write(i_internal_dma_write),
      .o_addr(i_internal_dma_addr));

   // steady processor clock, never stopped
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   // count boot words, enable ticks and cycle clock toggles
   always @(posedge i_clock) begin
      words += i_byte_dma_word_done;
      ce += o_core_clk_en;
      pe += o_periph_clk_en;
      tg += (o_cycle_clock_output !== cko_q);
      cko_q = o_cycle_clock_output;
   end

   task automatic check(input string nm, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   // expected enable ticks in a 512-cycle window for a divisor code
   function automatic int exp_ticks(input int code);
      return (code >= 4) ? (512 >> code) : 512;
   endfunction
   // expected {oe, out} of the acknowledge pin in host mode
   function automatic logic [1:0] exp_ack(input logic od, input logic act);
      return od ? {~act, 1'b1} : {1'b1, ~act};
   endfunction
   task automatic tk(input int k);
      repeat (k) @(posedge i_clock);
      #1;
   endtask
   // wait for execution, counting cycles up to a limit
   task automatic wait_run(input int lim);
      n = 0;
      while (o_run !== 1'b1 && n < lim) begin
         tk(1);
         n++;
      end
   endtask
   // master reset with straps d,c,b,a, then release and let the strap driver go
   task automatic boot(input logic [3:0] s);
      i_reset_pin_n <= 1'b0;
      i_strap_pins <= s;
      tk(5);
      check("clear", o_master_clear, 1'b1);
      check("flag", o_flag_pin_two_free, 1'b0);
      words = 0;
      i_reset_pin_n <= 1'b1;
      i_strap_pins <= ~s;
      wait_run(400);
      check("fetch", o_fetch_addr, 16'h0000);
   endtask
   task automatic report_and_stop;
      if (errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #400000;
      errors++;
      report_and_stop();
   end

   initial begin
      void'($urandom(29));
      {i_reset, i_reset_pin_n, i_powerdown_request_pin_n, i_bus_request_pin} = 4'ha;
      {i_powerdown_force, i_oscillator_disabled, i_irq_pending, i_idle_request} = 4'h0;
      {i_clock_output_disable_bit, i_host_ack_active, host_go, cko_q} = 4'h0;
      {i_strap_pins, i_dma_steal_request, gap} = 10'h000;
      i_internal_dma_to_pm = 1'b1;
      i_idle_divisor = DRIB_DIV_NONE;
      tk(8);
      i_reset <= 1'b0;
      gap <= 3'($urandom_range(0, 7));
      // byte boot in full or host mode, then no boot held by a bus request
      d = 1'($urandom);
      boot({1'($urandom), d, 2'b00});
      check("words", words >= 32, 1'b1);
      check("cfg", {o_config.host_mode, o_config.boot_src}, {d, DRIB_BOOT_BYTE});
      check("addr_oe", o_ext_addr_oe, d ? 14'h0001 : 14'h3fff);
      i_bus_request_pin <= 1'b1;
      boot({1'b0, 3'b010});
      check("bus_hold", o_run, 1'b0);
      i_bus_request_pin <= 1'b0;
      wait_run(8);
      check("ext", o_fetch_external, 1'b1);
      check("flag", o_flag_pin_two_free, 1'b1);
      // host boot: held until the host writes location zero
      d = 1'($urandom);
      boot({d, 3'b101});
      check("held", o_run, 1'b0);
      i_internal_dma_to_pm <= 1'b0;
      host_go <= 1'b1;
      tk(4);
      check("dm_held", o_run, 1'b0);
      host_go <= 1'b0;
      tk(1);
      i_internal_dma_to_pm <= 1'b1;
      host_go <= 1'b1;
      wait_run(8);
      check("host_run", o_run, 1'b1);
      check("cfg", {o_config.host_mode, o_config.ack_open_drain}, {1'b1, d});
      check("addr_oe", o_ext_addr_oe, 14'h0001);
      host_go <= 1'b0;
      for (int a = 0; a < 2; a++) begin
         i_host_ack_active <= a[0];
         tk(2);
         check("ack", {o_host_dma_acknowledge_oe, o_host_dma_acknowledge_out},
            exp_ack(d, a[0]));
      end
      // idle with each divisor code, one illegal
      foreach (codes[k]) begin
         sh = (codes[k] >= 4) ? codes[k] : 0;
         i_idle_divisor <= drib_div_t'(codes[k]);
         i_clock_output_disable_bit <= k[0];
         i_idle_request <= 1'b1;
         tk(1);
         i_idle_request <= 1'b0;
         i_dma_steal_request <= 3'($urandom);
         tk(3);
         {ce, pe, tg} = '0;
         tk(512);
         check("core_en", ce, exp_ticks(codes[k]));
         check("periph_en", pe, exp_ticks(codes[k]));
         check("cko", k[0] ? o_cycle_clock_output : tg, k[0] ? 0 : exp_ticks(codes[k]));
         check("grant", o_dma_grant, i_dma_steal_request);
         check("stall", o_run, 1'b0);
         i_irq_pending <= 1'b1;
         wait_run(140);
         check("resume", o_resume, 1'b1);
         check("wake", n <= (sh ? 1 << sh : 0) + 2, 1'b1);
         i_irq_pending <= 1'b0;
      end
      // power-down by force, by pin, then left by master reset
      for (int p = 0; p < 3; p++) begin
         i_oscillator_disabled <= p[0];
         rec = p[0] ? 20 : 400;
         {i_powerdown_force, i_powerdown_request_pin_n} <= (p == 0) ? 2'b11 : 2'b00;
         tk(4);
         check("pd_ack", o_powerdown_ack_pin, 1'b1);
         check("pd_run", o_run, 1'b0);
         {i_powerdown_force, i_powerdown_request_pin_n} <= 2'b01;
         tk(4);
         if (p == 2) begin
            i_reset_pin_n <= 1'b0;
            tk(4);
            check("rst_exit", {o_powerdown_ack_pin, o_master_clear}, 2'b01);
         end else begin
            i_irq_pending <= 1'b1;
            tk(1);
            i_irq_pending <= 1'b0;
            tk(1);
            check("ack_drop", o_powerdown_ack_pin, 1'b0);
            wait_run(500);
            check("recover", n <= rec && n + 8 >= rec, 1'b1);
         end
      end
      boot({1'b0, 3'b010});
      check("reboot", o_run, 1'b1);
      report_and_stop();
   end
endmodule
`default_nettype wire

// ===== verilog/drib_pkg.sv
// shared constants, types and state codes for the reset, idle and boot control block
// assumes one processor-cycle clock; the input clock pin runs at half this rate
package drib_pkg;

   // clock relations: processor cycle is twice the input clock rate
   localparam int          DRIB_CLOCK_MHZ         = 50;
   localparam int          DRIB_CYCLES_PER_IN_CLK = 2;
   localparam int          DRIB_EXAMPLE_IN_MHZ    = 40;  // gives a 12.5 ns cycle

   // power-down recovery, counted in input clock cycles
   localparam int          DRIB_PD_FAST_IN_CLKS   = 200;
   localparam int          DRIB_PD_SLOW_IN_CLKS   = 4096;
   localparam int          DRIB_REC_W             = 14;

   // boot constants
   localparam int          DRIB_BOOT_WORDS        = 32;
   localparam int          DRIB_BOOT_CNT_W        = 6;
   localparam logic [15:0] DRIB_FIRST_FETCH       = 16'h0000;
   localparam logic [15:0] DRIB_HOST_RELEASE_ADDR = 16'h0000;

   // external address drive masks
   localparam int          DRIB_EXT_ADDR_W        = 14;
   localparam logic [13:0] DRIB_HOST_ADDR_OE      = 14'h0001;
   localparam logic [13:0] DRIB_FULL_ADDR_OE      = 14'h3fff;

   // pin synchroniser layout: bus req, powerdown_n, reset_n, straps d..a
   localparam int          DRIB_SYNC_W            = 7;
   localparam logic [6:0]  DRIB_SYNC_RESET        = 7'h20;
   localparam int          DRIB_SYNC_BUS          = 6;
   localparam int          DRIB_SYNC_PD_N         = 5;
   localparam int          DRIB_SYNC_RST_N        = 4;

   // slow idle divisor code is log2 of the divisor
   typedef enum logic [2:0] {
      DRIB_DIV_NONE = 3'h0,
      DRIB_DIV_16   = 3'h4,
      DRIB_DIV_32   = 3'h5,
      DRIB_DIV_64   = 3'h6,
      DRIB_DIV_128  = 3'h7
   } drib_div_t;

   typedef enum logic [1:0] {
      DRIB_BOOT_BYTE = 2'h0,
      DRIB_BOOT_NONE = 2'h1,
      DRIB_BOOT_HOST = 2'h2
   } drib_boot_t;

   typedef struct packed {
      logic d;
      logic c;
      logic b;
      logic a;
   } drib_strap_t;

   typedef struct packed {
      logic       host_mode;
      logic       ack_open_drain;
      drib_boot_t boot_src;
   } drib_cfg_t;

   localparam drib_cfg_t   DRIB_CFG_RESET = '{host_mode: 1'b0, ack_open_drain: 1'b0,
                                              boot_src: DRIB_BOOT_NONE};

   typedef enum logic [5:0] {
      DRIB_ST_RESET   = 6'h01,
      DRIB_ST_BOOT    = 6'h02,
      DRIB_ST_RUN     = 6'h04,
      DRIB_ST_IDLE    = 6'h08,
      DRIB_ST_PWRDN   = 6'h10,
      DRIB_ST_RECOVER = 6'h20
   } drib_state_t;

endpackage

// ===== verilog/drib_slow_divider.sv
// clock-enable divider for slow idle: one tick every 2**code cycles
// assumes the divisor only changes while i_restart is high
`timescale 1ns/1ps
`default_nettype none
module drib_slow_divider #(
   parameter int CNT_W = 7
) (
   input  wire logic              i_clock,
   input  wire logic              i_reset,
   input  wire logic              i_restart,
   input  wire drib_pkg::drib_div_t i_div,
   output logic                   o_tick
);
   import drib_pkg::*;

   if (CNT_W < 7) begin : g_chk
      $error("divider counter too narrow for a divisor of 128");
   end

   logic [CNT_W-1:0] count;

   // division limit decode
   wire logic             slow     = (i_div >= DRIB_DIV_16);
   wire logic [CNT_W-1:0] limit    = CNT_W'((32'd1 << i_div) - 32'd1);
   wire logic             at_limit = (count == limit);

   // count runs only in a divided mode; tick every cycle otherwise
   always_ff @(posedge i_clock) begin
      if (i_reset || i_restart || !slow || at_limit) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
      o_tick <= i_reset || !slow || at_limit;
   end

endmodule
`default_nettype wire

// ===== verilog/drib_sysctl.sv
// power-down, idle, slow idle, cycle clock and master reset/boot sequencing
// assumes i_clock is the processor cycle clock and pins arrive asynchronously
//
// Behaviour
// - master reset during power-down ends power-down
// - power-down acknowledge goes active once power-down is fully entered
// - idle stalls until an unmasked interrupt, then resumes after the idle
// - dma and autobuffer cycle steals keep being granted while idle
// - slow idle divides the core clock by 16, 32, 64 or 128
// - serial, cycle-clock and timer enables divide by the same ratio
// - idle without a divisor is plain idle with no division
// - after a wake interrupt, slow idle lasts at most the divisor cycles
// - processor cycle runs at twice the input clock rate
// - cycle clock output toggles per cycle, gated off by the disable bit
// - later resets keep clocks running with no stabilisation wait
// - master reset empties stacks, masks interrupts, clears mode status
// - on release, no bus request, boot then fetch from internal 0x0000
// - straps c,b,a low: byte dma loads 32 words, full memory mode
// - strap b high only: no boot, start external 0, full memory mode
// - straps c,a high, b low: host mode, wait host write to location 0
// - memory mode latched from strap c only during reset
// - strap d selects driven or open-drain host dma acknowledge
// - host memory mode drives only one external address bit
// - power-down entered by request pin or software force bit
// - restart within 200 input clocks, or 4096 with oscillator stopped
`timescale 1ns/1ps
`default_nettype none
module drib_sysctl #(
   parameter int SLOW_REC_CYCLES = drib_pkg::DRIB_PD_SLOW_IN_CLKS * drib_pkg::DRIB_CYCLES_PER_IN_CLK
) (
   input  wire logic                  i_clock,
   input  wire logic                  i_reset,
   input  wire logic                  i_reset_pin_n,
   input  wire logic                  i_powerdown_request_pin_n,
   input  wire logic                  i_bus_request_pin,
   input  wire drib_pkg::drib_strap_t i_strap_pins,
   input  wire logic                  i_powerdown_force,
   input  wire logic                  i_oscillator_disabled,
   input  wire logic                  i_irq_pending,
   input  wire logic                  i_idle_request,
   input  wire drib_pkg::drib_div_t   i_idle_divisor,
   input  wire logic [2:0]            i_dma_steal_request,
   input  wire logic                  i_clock_output_disable_bit,
   input  wire logic                  i_byte_dma_word_done,
   input  wire logic                  i_internal_dma_write,
   input  wire logic                  i_internal_dma_to_pm,
   input  wire logic [15:0]           i_internal_dma_addr,
   input  wire logic                  i_host_ack_active,
   output logic                       o_powerdown_ack_pin,
   output logic                       o_master_clear,
   output logic                       o_run,
   output logic                       o_resume,
   output logic                       o_fetch_external,
   output logic [15:0]                o_fetch_addr,
   output logic                       o_byte_dma_boot,
   output logic [2:0]                 o_dma_grant,
   output logic                       o_core_clk_en,
   output logic                       o_periph_clk_en,
   output logic                       o_cycle_clock_output,
   output drib_pkg::drib_cfg_t        o_config,
   output logic                       o_flag_pin_two_free,
   output logic                       o_host_dma_acknowledge_out,
   output logic                       o_host_dma_acknowledge_oe,
   output logic [13:0]                o_ext_addr_oe
);
   import drib_pkg::*;

   localparam int FAST_REC_CYCLES = DRIB_PD_FAST_IN_CLKS * DRIB_CYCLES_PER_IN_CLK;

   if (SLOW_REC_CYCLES < 1 || SLOW_REC_CYCLES >= (1 << DRIB_REC_W)) begin : g_chk
      $error("slow recovery count out of range");
   end

   logic [DRIB_SYNC_W-1:0]     sync_a;
   logic [DRIB_SYNC_W-1:0]     sync_b;
   drib_state_t                state;
   drib_state_t                next_state;
   drib_div_t                  idle_div;
   logic                       wake_seen;
   logic [DRIB_BOOT_CNT_W-1:0] word_count;
   logic [DRIB_REC_W-1:0]      rec_count;
   logic                       tick;

   // two-flop synchroniser for every pin input
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         sync_a <= DRIB_SYNC_RESET;
         sync_b <= DRIB_SYNC_RESET;
      end else begin
         sync_a <= {i_bus_request_pin, i_powerdown_request_pin_n, i_reset_pin_n, i_strap_pins};
         sync_b <= sync_a;
      end
   end

   // synchronised pin decode
   wire logic        mreset    = !sync_b[DRIB_SYNC_RST_N];
   wire logic        pd_pin    = !sync_b[DRIB_SYNC_PD_N];
   wire logic        bus_req   = sync_b[DRIB_SYNC_BUS];
   wire drib_strap_t strap_now = drib_strap_t'(sync_b[3:0]);

   // strap decode into boot source and memory mode
   wire logic       strap_byte_full = !strap_now.c && !strap_now.b && !strap_now.a;
   wire logic       strap_none_full = !strap_now.c && strap_now.b && !strap_now.a;
   wire logic       strap_host_load = strap_now.c && !strap_now.b && strap_now.a;
   wire logic       strap_byte_host = strap_now.c && !strap_now.b && !strap_now.a;
   wire drib_boot_t next_src        = (strap_byte_full || strap_byte_host) ? DRIB_BOOT_BYTE :
                                      strap_host_load ? DRIB_BOOT_HOST : DRIB_BOOT_NONE;
   wire drib_cfg_t  next_cfg        = '{host_mode: strap_now.c, ack_open_drain: strap_now.d,
                                        boot_src: next_src};

   // boot completion terms
   wire logic byte_done    = (word_count == DRIB_BOOT_CNT_W'(DRIB_BOOT_WORDS));
   wire logic host_release = i_internal_dma_write && i_internal_dma_to_pm &&
                             (i_internal_dma_addr == DRIB_HOST_RELEASE_ADDR);
   wire logic boot_go      = !bus_req && ((o_config.boot_src == DRIB_BOOT_NONE) ||
                             (o_config.boot_src == DRIB_BOOT_BYTE && byte_done) ||
                             (o_config.boot_src == DRIB_BOOT_HOST && host_release));

   // power-down, idle and divisor terms
   wire logic      pd_req     = pd_pin || i_powerdown_force;
   wire logic      div_legal  = (i_idle_divisor inside {DRIB_DIV_16, DRIB_DIV_32,
                                                        DRIB_DIV_64, DRIB_DIV_128});
   wire drib_div_t entry_div  = div_legal ? i_idle_divisor : DRIB_DIV_NONE;
   wire drib_div_t active_div = (state == DRIB_ST_IDLE) ? idle_div : DRIB_DIV_NONE;
   wire logic      idle_tick  = (idle_div == DRIB_DIV_NONE) || tick;
   wire logic      rec_done   = (rec_count == DRIB_REC_W'(1));
   wire logic [DRIB_REC_W-1:0] rec_load = i_oscillator_disabled ?
                                          DRIB_REC_W'(SLOW_REC_CYCLES) :
                                          DRIB_REC_W'(FAST_REC_CYCLES);

   // core clock divider; restarts whenever the core is not idle
   drib_slow_divider #(
      .CNT_W (7)
   ) u_divider (
      .i_clock   (i_clock),
      .i_reset   (i_reset),
      .i_restart (state != DRIB_ST_IDLE),
      .i_div     (active_div),
      .o_tick    (tick)
   );

   // sequencing; master reset overrides every state
   always_comb begin
      next_state = state;
      if (mreset) begin
         next_state = DRIB_ST_RESET;
      end else begin
         unique case (state)
            DRIB_ST_RESET: begin
               next_state = DRIB_ST_BOOT;
            end
            DRIB_ST_BOOT: begin
               if (boot_go) next_state = DRIB_ST_RUN;
            end
            DRIB_ST_RUN: begin
               if (pd_req) next_state = DRIB_ST_PWRDN;
               else if (i_idle_request) next_state = DRIB_ST_IDLE;
            end
            DRIB_ST_IDLE: begin
               if (pd_req) next_state = DRIB_ST_PWRDN;
               else if ((i_irq_pending || wake_seen) && idle_tick) next_state = DRIB_ST_RUN;
            end
            DRIB_ST_PWRDN: begin
               if (i_irq_pending) next_state = DRIB_ST_RECOVER;
            end
            DRIB_ST_RECOVER: begin
               if (rec_done) next_state = DRIB_ST_RUN;
            end
            default: begin
               next_state = DRIB_ST_RESET;
            end
         endcase
      end
   end

   // state, idle divisor and wake memory
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         state     <= DRIB_ST_RESET;
         idle_div  <= DRIB_DIV_NONE;
         wake_seen <= 1'b0;
      end else begin
         state     <= next_state;
         idle_div  <= (state == DRIB_ST_RUN) ? entry_div : idle_div;
         wake_seen <= (state == DRIB_ST_IDLE) && (i_irq_pending || wake_seen);
      end
   end

   // boot word count and recovery count
   always_ff @(posedge i_clock) begin
      if (i_reset || state != DRIB_ST_BOOT) begin
         word_count <= '0;
      end else if (i_byte_dma_word_done && !byte_done) begin
         word_count <= word_count + 1'b1;
      end
      if (i_reset || state != DRIB_ST_RECOVER) begin
         rec_count <= rec_load;
      end else begin
         rec_count <= rec_count - 1'b1;
      end
   end

   // mode straps latched only while master reset is held
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_config      <= DRIB_CFG_RESET;
         o_ext_addr_oe <= DRIB_FULL_ADDR_OE;
      end else begin
         o_config      <= mreset ? next_cfg : o_config;
         o_ext_addr_oe <= o_config.host_mode ? DRIB_HOST_ADDR_OE : DRIB_FULL_ADDR_OE;
      end
   end

   // status and control outputs
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_powerdown_ack_pin <= 1'b0;
         o_master_clear      <= 1'b1;
         o_run               <= 1'b0;
         o_resume            <= 1'b0;
         o_fetch_external    <= 1'b0;
         o_fetch_addr        <= DRIB_FIRST_FETCH;
         o_byte_dma_boot     <= 1'b0;
         o_dma_grant         <= '0;
         o_flag_pin_two_free <= 1'b0;
      end else begin
         o_powerdown_ack_pin <= (next_state == DRIB_ST_PWRDN);
         o_master_clear      <= mreset;
         o_run               <= (next_state == DRIB_ST_RUN);
         o_resume            <= (state == DRIB_ST_IDLE) && (next_state == DRIB_ST_RUN);
         o_fetch_external    <= (o_config.boot_src == DRIB_BOOT_NONE);
         o_fetch_addr        <= DRIB_FIRST_FETCH;
         o_byte_dma_boot     <= (next_state == DRIB_ST_BOOT) && !bus_req &&
                                (o_config.boot_src == DRIB_BOOT_BYTE) && !byte_done;
         o_dma_grant         <= (state == DRIB_ST_RUN || state == DRIB_ST_IDLE) ?
                                i_dma_steal_request : 3'h0;
         o_flag_pin_two_free <= !mreset;
      end
   end

   // cycle clock output and its gating; runs at the divided rate in slow idle
   always_ff @(posedge i_clock) begin
      if (i_reset || i_clock_output_disable_bit) begin
         o_cycle_clock_output <= 1'b0;
      end else if (tick) begin
         o_cycle_clock_output <= !o_cycle_clock_output;
      end
   end

   // core and peripheral enables share one divider flop
   assign o_core_clk_en   = tick;
   assign o_periph_clk_en = tick;

   // host dma acknowledge pin: driven or open-drain, host mode only
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_host_dma_acknowledge_out <= 1'b1;
         o_host_dma_acknowledge_oe  <= 1'b0;
      end else begin
         o_host_dma_acknowledge_out <= o_config.ack_open_drain || !i_host_ack_active;
         o_host_dma_acknowledge_oe  <= o_config.host_mode &&
                                       (!o_config.ack_open_drain || !i_host_ack_active);
      end
   end

   // checks
   chk_reset_ends_pd: assert property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_PWRDN && mreset) |=> (state == DRIB_ST_RESET && !o_powerdown_ack_pin))
      else $error("master reset did not end power-down");
   chk_pd_ack_level: assert property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_PWRDN) == o_powerdown_ack_pin)
      else $error("power-down acknowledge out of step with state");
   chk_idle_wake_fast: assert property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_IDLE && idle_div == DRIB_DIV_NONE && i_irq_pending && !pd_req && !mreset)
      |=> (state == DRIB_ST_RUN && o_resume))
      else $error("plain idle did not resume in one cycle");
   chk_idle_grants: assert property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_IDLE && !mreset) |=> (o_dma_grant == $past(i_dma_steal_request)))
      else $error("cycle steal not granted in idle");
   chk_slow_wake_bound: assert property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_IDLE && i_irq_pending) |-> ##[1:129] (state != DRIB_ST_IDLE))
      else $error("slow idle exceeded divisor cycles after wake");
   chk_slow_no_tick: assert property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_IDLE && idle_div == DRIB_DIV_16 && $past(state) == DRIB_ST_IDLE && tick)
      |=> (!tick || state != DRIB_ST_IDLE) [*8])
      else $error("slow idle tick came too soon");
   chk_cycle_clock_output_gated: assert property (@(posedge i_clock) disable iff (i_reset)
      i_clock_output_disable_bit |=> !o_cycle_clock_output)
      else $error("cycle clock not gated off");
   chk_master_clear: assert property (@(posedge i_clock) disable iff (i_reset)
      mreset |=> (o_master_clear && !o_run))
      else $error("master reset did not clear state");
   chk_byte_boot_hold: assert property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_BOOT && o_config.boot_src == DRIB_BOOT_BYTE && !byte_done)
      |=> (state != DRIB_ST_RUN))
      else $error("ran before 32 boot words");
   chk_host_release: assert property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_BOOT && o_config.boot_src == DRIB_BOOT_HOST && host_release &&
       !bus_req && !mreset) |=> o_run)
      else $error("host write to location zero did not start execution");
   chk_host_addr: assert property (@(posedge i_clock) disable iff (i_reset)
      o_config.host_mode |=> (o_ext_addr_oe == DRIB_HOST_ADDR_OE))
      else $error("host mode drives more than one address bit");
   chk_fast_recovery: assert property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_PWRDN && i_irq_pending && !i_oscillator_disabled)
      |-> ##[1:401] (state == DRIB_ST_RUN || state == DRIB_ST_RESET))
      else $error("power-down recovery too slow");

   cov_slow_wake: cover property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_IDLE && idle_div == DRIB_DIV_128) ##1 o_resume);
   cov_host_boot: cover property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_BOOT && o_config.boot_src == DRIB_BOOT_HOST) ##1 (state == DRIB_ST_RUN));
   cov_pd_recover: cover property (@(posedge i_clock) disable iff (i_reset)
      (state == DRIB_ST_RECOVER) ##1 (state == DRIB_ST_RUN));

endmodule
`default_nettype wire
